/* File: logic/microcore_mode_set_decoder.v */
// Purpose: executes shift-right-signed-immediate and mode-select instructions
//   for one microcore, and keeps the selections they make
// Assumes: instructions arrive as a one-cycle valid word on pclk
//   access rights arrive as levels from the configuration registers
// Notes: selections visible over apb; alu registers live here too
//   apb has one wait state; writes land on the edge that completes them
//
// Functional notes
// - signed right shift keeps sign bit
// - shift takes shift_amount cycles
// - shift updates shifted-out and overflow flags
// - shift amount bits 6:3, target 2:0
// - base source 0 pointer, 1 index
// - reset selects base pointer register
// - reference bit: 0 boost, 1 battery
// - diag: 00 keep, 10 off, 11 on
// - feedback select needs drive right
// - reset selects boost reference
// - serial address 0 register, 1 index
// - reset selects serial address register
// - load base writes six-bit pointer
// - conversion bit: 0 compare, 1 convert
// - target code picks block
// - conversion mode needs access right
// - reset clears all conversion modes
// - arith mode stored in condition bits
// - signed wrap flags overflow, no clamp
// - signed clamp flags and clamps
// - reset mode is unsigned wrap
// - mode encoding 00..11 as listed
`timescale 1ns/100ps
`include "mode_set_consts.vh"

module microcore_mode_set_decoder #(
  parameter DATA_W = 16,
  parameter NUM_ALU_REGS = 8,
  parameter CORE_ID = 2'h0
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // instruction stream
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [DATA_W-1:0] alu_index_register,
  output reg instr_busy,
  // access rights from configuration
  input wire hs_drive_right,
  input wire [3:0] sense_block_rights,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // selections towards the datapath
  output reg [5:0] base_pointer_reg,
  output reg [5:0] indexed_base,
  output reg serial_addr_is_index,
  output reg hs_fbk_battery,
  output reg auto_diag_enable,
  output reg [3:0] conversion_mode,
  output reg [1:0] arith_mode,
  output reg shifted_out_flag,
  output reg multiply_shift_overflow,
  output reg alu_overflow
);

// ----------------------------------------
// decode
// ----------------------------------------
reg [DATA_W-1:0] alu_regs [0:NUM_ALU_REGS-1];
reg base_src_is_index;
reg [3:0] shift_left;
reg [2:0] shift_tgt;
integer i;

// clamp limits of the result register
localparam [DATA_W-1:0] SIGNED_MAX = {1'b0, {(DATA_W-1){1'b1}}};
localparam [DATA_W-1:0] SIGNED_MIN = {1'b1, {(DATA_W-1){1'b0}}};
localparam [DATA_W-1:0] UNSIGNED_MAX = {DATA_W{1'b1}};

// true for the four mapped offsets, anything else is an error
function addr_mapped;
  input [11:0] addr;
  begin
    addr_mapped = (addr == `ADDR_CTRL) || (addr == `ADDR_STATUS) ||
                  (addr == `ADDR_ALU_REG) || (addr == `ADDR_RIGHTS);
  end
endfunction

// next diagnosis enable; keep and the unused code leave it alone
function next_diag;
  input [1:0] code;
  input current;
  begin
    case (code)
      `DIAG_OFF: next_diag = 1'b0;
      `DIAG_ON: next_diag = 1'b1;
      default: next_diag = current;
    endcase
  end
endfunction

// block position relative to this core, sssc..osoc
function [1:0] block_of;
  input [1:0] target;
  begin
    block_of = target ^ CORE_ID;
  end
endfunction

// instruction match, valid only when not shifting
wire take = instr_valid && !instr_busy;
wire is_shift = take && instr_word[`OPC_SHIFT_RSI_MSB:`OPC_SHIFT_RSI_LSB] == `OPC_SHIFT_RSI;
// mode selections carry their operand in the low bits
wire is_base_src = take && instr_word[15:1] == `OPC_BASE_SRC;
wire is_serial_src = take && instr_word[15:1] == `OPC_SERIAL_SRC;
wire is_hs_fbk = take && instr_word[15:3] == `OPC_HS_FBK;
wire is_load_base = take && instr_word[15:6] == `OPC_LOAD_BASE;
wire is_conv = take && instr_word[15:3] == `OPC_CONV_MODE;
wire is_arith = take && instr_word[15:2] == `OPC_ARITH_MODE;
// shift operands
wire [3:0] shamt = instr_word[`SHAMT_MSB:`SHAMT_LSB];
wire [2:0] tgt = instr_word[`TGT_MSB:`TGT_LSB];
// current block named relative to this core
wire [1:0] conv_target = instr_word[1:0];
wire [1:0] conv_block = block_of(conv_target);
wire [DATA_W-1:0] cur_val = alu_regs[shift_tgt];
// one step of arithmetic shift, sign bit held
wire [DATA_W-1:0] stepped = {cur_val[DATA_W-1], cur_val[DATA_W-1:1]};

// apb phases: access cycle before and with the answer
wire apb_access = psel && penable && !pready;
wire apb_done = psel && penable && pready;
// a write takes effect only on the edge that completes it
wire apb_wr = apb_done && pwrite;
// rights gating; a refused instruction changes nothing
wire fbk_allowed = is_hs_fbk && hs_drive_right;
wire conv_allowed = is_conv && sense_block_rights[conv_block];

// ----------------------------------------
// shift engine, one bit per cycle
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    instr_busy <= 1'b0;
    shift_left <= 4'h0;
    shift_tgt <= 3'h0;
    shifted_out_flag <= 1'b0;
    multiply_shift_overflow <= 1'b0;
    for (i = 0; i < NUM_ALU_REGS; i = i + 1) begin
      alu_regs[i] <= {DATA_W{1'b0}};
    end
  end else if (is_shift) begin
    // the take edge loads the counter; a zero count never goes busy
    shift_tgt <= tgt;
    shift_left <= shamt;
    instr_busy <= (shamt != 4'h0);
    shifted_out_flag <= 1'b0;
    multiply_shift_overflow <= 1'b0; // no bits can overflow a right shift
  end else if (instr_busy) begin
    alu_regs[shift_tgt] <= stepped;
    shifted_out_flag <= cur_val[0];
    shift_left <= shift_left - 4'h1;
    instr_busy <= (shift_left != 4'h1);
  end else if (apb_wr && paddr == `ADDR_ALU_REG) begin
    // software preload, target chosen by pwdata[18:16]
    // a preload that lands while a shift runs is lost
    alu_regs[pwdata[18:16]] <= pwdata[DATA_W-1:0];
  end
end

// ----------------------------------------
// mode selections
// ----------------------------------------
// one process per mode instruction keeps every reset value easy to audit
// data-ram base source: pointer register or index register
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    base_src_is_index <= `RST_BASE_SRC;
  end else if (is_base_src) begin
    base_src_is_index <= instr_word[0];
  end
end

// serial address source: address register or index register
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    serial_addr_is_index <= `RST_SERIAL_SRC;
  end else if (is_serial_src) begin
    serial_addr_is_index <= instr_word[0];
  end
end

// base pointer, six bits straight from the operand
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    base_pointer_reg <= `RST_BASE_VALUE;
  end else if (is_load_base) begin
    base_pointer_reg <= instr_word[`BASE_MSB:`BASE_LSB];
  end
end

// high-side 2/4 feedback reference and automatic diagnosis
// without drive right the instruction is silently dropped
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    hs_fbk_battery <= `RST_FBK_REF;
    auto_diag_enable <= `RST_AUTO_DIAG;
  end else if (fbk_allowed) begin
    hs_fbk_battery <= instr_word[2];
    auto_diag_enable <= next_diag(instr_word[1:0], auto_diag_enable);
  end
end

// conversion mode, one bit per current block
// a refused request leaves every block as it was
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    conversion_mode <= `RST_CONV_MODE;
  end else if (conv_allowed) begin
    conversion_mode[conv_block] <= instr_word[2];
  end
end

// arithmetic mode bits of the condition register
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    arith_mode <= `RST_ARITH_MODE;
  end else if (is_arith) begin
    arith_mode <= instr_word[1:0];
  end
end

// registered base choice keeps the output straight from a flop
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    indexed_base <= `RST_BASE_VALUE;
  end else if (base_src_is_index) begin
    indexed_base <= alu_index_register[5:0];
  end else begin
    indexed_base <= base_pointer_reg;
  end
end

// ----------------------------------------
// overflow check per arithmetic mode
// ----------------------------------------
// adds apb operand to index register; shows wrap/clamp result
reg [DATA_W-1:0] next_sum;
reg next_ovf;
wire [DATA_W:0] raw_sum = {1'b0, alu_index_register} + {1'b0, pwdata[DATA_W-1:0]};
wire s_ovf = (alu_index_register[DATA_W-1] == pwdata[DATA_W-1]) &&
             (raw_sum[DATA_W-1] != alu_index_register[DATA_W-1]);
always @* begin
  next_sum = raw_sum[DATA_W-1:0];
  next_ovf = 1'b0;
  case (arith_mode)
    `MODE_SIGNED_WRAP: begin
      next_ovf = s_ovf;
    end
    `MODE_SIGNED_CLAMP: begin
      next_ovf = s_ovf;
      if (s_ovf) begin
        // a positive index can only overflow upward
        next_sum = alu_index_register[DATA_W-1] ? SIGNED_MIN : SIGNED_MAX;
      end
    end
    `MODE_UNSIGNED_WRAP: begin
      next_ovf = raw_sum[DATA_W];
    end
    `MODE_UNSIGNED_CLAMP: begin
      next_ovf = raw_sum[DATA_W];
      if (raw_sum[DATA_W]) begin
        next_sum = UNSIGNED_MAX;
      end
    end
    default: begin
      next_ovf = 1'b0;
    end
  endcase
end

// result and flag hold until the next control write
reg [DATA_W-1:0] arith_result;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    arith_result <= {DATA_W{1'b0}};
    alu_overflow <= 1'b0;
  end else if (apb_wr && paddr == `ADDR_CTRL) begin
    arith_result <= next_sum;
    alu_overflow <= next_ovf;
  end
end

// ----------------------------------------
// apb slave, one wait state
// ----------------------------------------
// status word, low bits first: base, serial, ref, diag, conv, mode, flags, busy
wire [31:0] status_word = {18'h00000,
                           instr_busy,
                           alu_overflow,
                           multiply_shift_overflow,
                           shifted_out_flag,
                           arith_mode,
                           conversion_mode,
                           auto_diag_enable,
                           hs_fbk_battery,
                           serial_addr_is_index,
                           base_src_is_index};
// alu register picked for reads, index in pwdata[18:16]
wire [DATA_W-1:0] alu_read = alu_regs[pwdata[18:16]];

// read data latched in the first access cycle, stands until the next access, read or write
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h00000000;
    pready <= 1'b0;
    pslverr <= 1'b0;
  end else begin
    // pready answers one cycle into access phase, then drops again
    pready <= apb_access;
    // only an unmapped offset is refused
    pslverr <= apb_access && !addr_mapped(paddr);
    if (apb_access) begin
      case (paddr)
        `ADDR_CTRL: prdata <= {{(32-DATA_W){1'b0}}, arith_result};
        `ADDR_STATUS: prdata <= status_word;
        `ADDR_ALU_REG: prdata <= {{(32-DATA_W){1'b0}}, alu_read};
        `ADDR_RIGHTS: prdata <= {20'h00000, base_pointer_reg, indexed_base};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
end

endmodule

/* File: logic/mode_set_consts.vh */
// Purpose: constants for the microcore mode-set decoder
// Assumes: 16-bit instruction words from code ram
// Notes: opcode patterns, field positions, reset selections
`ifndef MODE_SET_CONSTS_VH
`define MODE_SET_CONSTS_VH

// opcode patterns of the upper bits
`define OPC_SHIFT_RSI 9'h04f
`define OPC_SHIFT_RSI_MSB 15
`define OPC_SHIFT_RSI_LSB 7
`define OPC_BASE_SRC 15'h1b05
`define OPC_SERIAL_SRC 15'h1b04
`define OPC_HS_FBK 13'h06c8
`define OPC_LOAD_BASE 10'h0d0
`define OPC_CONV_MODE 13'h06ad
`define OPC_ARITH_MODE 14'h0d5f

// operand field positions
`define SHAMT_MSB 6
`define SHAMT_LSB 3
`define TGT_MSB 2
`define TGT_LSB 0
`define BASE_MSB 5
`define BASE_LSB 0

// reset selections
`define RST_BASE_SRC 1'b0
`define RST_SERIAL_SRC 1'b0
`define RST_FBK_REF 1'b0
`define RST_AUTO_DIAG 1'b0
`define RST_CONV_MODE 4'h0
`define RST_ARITH_MODE 2'h2
`define RST_BASE_VALUE 6'h00

// arithmetic modes
`define MODE_SIGNED_WRAP 2'h0
`define MODE_SIGNED_CLAMP 2'h1
`define MODE_UNSIGNED_WRAP 2'h2
`define MODE_UNSIGNED_CLAMP 2'h3

// automatic diagnosis codes
`define DIAG_KEEP 2'h0
`define DIAG_OFF 2'h2
`define DIAG_ON 2'h3

// apb offsets
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_ALU_REG 12'h008
`define ADDR_RIGHTS 12'h00c

`endif

/* File: tb/mode_set_checker_asserts.sv */
// Purpose: port assertions for the mode-set decoder
// Assumes: one pclk domain, presetn async low
// Notes: bound into every decoder instance
`timescale 1ns/100ps
`include "mode_set_consts.vh"
module mode_set_checker #(
  parameter CORE_ID = 2'h0
) (
  // clock, reset, stream
  input wire pclk,
  input wire presetn,
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire instr_busy,
  // rights
  input wire hs_drive_right,
  input wire [3:0] sense_block_rights,
  // selections
  input wire [5:0] base_pointer_reg,
  input wire serial_addr_is_index,
  input wire hs_fbk_battery,
  input wire auto_diag_enable,
  input wire [3:0] conversion_mode,
  input wire [1:0] arith_mode,
  input wire multiply_shift_overflow
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decoded takes, mirrored from the opcode patterns
  wire take = instr_valid && !instr_busy;
  wire is_shift = take && (instr_word[15:7] == `OPC_SHIFT_RSI);
  wire is_fbk = take && (instr_word[15:3] == `OPC_HS_FBK);
  wire is_conv = take && (instr_word[15:3] == `OPC_CONV_MODE);
  wire [1:0] blk = instr_word[1:0] ^ CORE_ID[1:0];
  reg [3:0] busy_cnt;
  reg [3:0] shift_n;
  // busy cycles since the last take; a counter avoids long repetitions
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 4'h0;
      shift_n <= 4'h0;
    end else if (take) begin
      busy_cnt <= 4'h0;
      shift_n <= instr_word[6:3];
    end else if (instr_busy) begin
      busy_cnt <= busy_cnt + 4'h1;
    end
  end
  a_shift_start: assert property (is_shift && instr_word[6:3] != 4'h0 |=> instr_busy)
    else $error("shift did not start");
  a_shift_none: assert property (is_shift && instr_word[6:3] == 4'h0 |=> !instr_busy)
    else $error("empty shift went busy");
  a_shift_length: assert property ($fell(instr_busy) |-> busy_cnt == shift_n && !multiply_shift_overflow)
    else $error("shift length or overflow flag wrong");
  a_base_load: assert property (take && instr_word[15:6] == `OPC_LOAD_BASE |=>
    base_pointer_reg == $past(instr_word[5:0]))
    else $error("base pointer not loaded");
  a_serial_src: assert property (take && instr_word[15:1] == `OPC_SERIAL_SRC |=>
    serial_addr_is_index == $past(instr_word[0]))
    else $error("serial address source wrong");
  a_fbk_denied: assert property (is_fbk && !hs_drive_right |=> $stable({hs_fbk_battery, auto_diag_enable}))
    else $error("feedback changed without right");
  a_fbk_ref: assert property (is_fbk && hs_drive_right |=> hs_fbk_battery == $past(instr_word[2]))
    else $error("feedback reference wrong");
  a_diag_set: assert property (is_fbk && hs_drive_right |=>
    auto_diag_enable == ($past(instr_word[1]) ? $past(instr_word[0]) : $past(auto_diag_enable)))
    else $error("diagnosis setting wrong");
  a_conv_denied: assert property (is_conv && !sense_block_rights[blk] |=> $stable(conversion_mode))
    else $error("conversion changed without right");
  a_conv_set: assert property (is_conv && sense_block_rights[blk] |=>
    conversion_mode[$past(blk)] == $past(instr_word[2]))
    else $error("conversion mode wrong");
  a_arith_set: assert property (take && instr_word[15:2] == `OPC_ARITH_MODE |=>
    arith_mode == $past(instr_word[1:0]))
    else $error("arithmetic mode wrong");
endmodule
bind microcore_mode_set_decoder mode_set_checker #(.CORE_ID(CORE_ID)) u_checker (.pclk(pclk), .presetn(presetn),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_busy(instr_busy), .hs_drive_right(hs_drive_right),
  .sense_block_rights(sense_block_rights), .base_pointer_reg(base_pointer_reg),
  .serial_addr_is_index(serial_addr_is_index), .hs_fbk_battery(hs_fbk_battery),
  .auto_diag_enable(auto_diag_enable), .conversion_mode(conversion_mode), .arith_mode(arith_mode),
  .multiply_shift_overflow(multiply_shift_overflow));

/* File: tb/code_ram_feeder.sv */
// Purpose: code ram side, hands one instruction word per push
// Assumes: bench pushes only while the decoder is idle
// Notes: the word toggles when not valid, so stale words never match
`timescale 1ns/100ps
module code_ram_feeder (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // bench request
  input wire push,
  input wire [15:0] push_word,
  // instruction stream
  output reg instr_valid,
  output reg [15:0] instr_word
);
  // one-cycle valid word per push
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_valid <= 1'b0;
      instr_word <= 16'hffff;
    end else if (push) begin
      instr_valid <= 1'b1;
      instr_word <= push_word;
    end else begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end
  end
endmodule

/* File: tb/tb_microcore_mode_set_decoder.sv */
// Purpose: directed bench for the mode-set decoder
// Assumes: CORE_ID 1, so target code t reaches block t xor 1
// Notes: registers reached over apb, instructions through the feeder
`timescale 1ns/100ps
`include "mode_set_consts.vh"
module tb_microcore_mode_set_decoder;
  reg pclk, presetn, push, hs_drive_right, psel, penable, pwrite, err;
  reg [15:0] push_word, alu_index_register;
  reg [3:0] sense_block_rights;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  wire instr_valid, instr_busy, pready, pslverr, serial_addr_is_index, hs_fbk_battery, auto_diag_enable;
  wire shifted_out_flag, multiply_shift_overflow, alu_overflow;
  wire [15:0] instr_word;
  wire [31:0] prdata;
  wire [5:0] base_pointer_reg, indexed_base;
  wire [3:0] conversion_mode;
  wire [1:0] arith_mode;
  integer n_fail, checked, cycles, i;
  code_ram_feeder u_feed (.pclk(pclk), .presetn(presetn), .push(push), .push_word(push_word),
    .instr_valid(instr_valid), .instr_word(instr_word));
  microcore_mode_set_decoder #(.CORE_ID(2'h1)) DUT (.pclk(pclk), .presetn(presetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .alu_index_register(alu_index_register), .instr_busy(instr_busy),
    .hs_drive_right(hs_drive_right), .sense_block_rights(sense_block_rights), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .base_pointer_reg(base_pointer_reg), .indexed_base(indexed_base), .serial_addr_is_index(serial_addr_is_index),
    .hs_fbk_battery(hs_fbk_battery), .auto_diag_enable(auto_diag_enable), .conversion_mode(conversion_mode),
    .arith_mode(arith_mode), .shifted_out_flag(shifted_out_flag),
    .multiply_shift_overflow(multiply_shift_overflow), .alu_overflow(alu_overflow));
  task complete_run;
    begin
      if (n_fail == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
        n_fail = n_fail + 1;
      end
    end
  endtask
  // one apb transfer; a spare edge at the end keeps psel from two writes in one step
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // push one word, let it be taken, then wait out any shift
  task issue(input [15:0] w);
    begin
      push <= 1'b1; push_word <= w;
      @(posedge pclk);
      push <= 1'b0;
      repeat (2) @(posedge pclk);
      while (instr_busy === 1'b1) @(posedge pclk);
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard, far above the roughly 140 cycles needed
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  initial begin
    n_fail = 0; checked = 0; cycles = 0; presetn = 1'b0; push = 1'b0; push_word = 16'h0000;
    alu_index_register = 16'h0015; hs_drive_right = 1'b0; sense_block_rights = 4'hb;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("status", 32'h0000_0200, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    issue({`OPC_LOAD_BASE, 6'h2a});
    chk("base_ptr", 32'h2a, 32'(base_pointer_reg));
    for (i = 1; i >= 0; i = i - 1) begin
      issue({`OPC_BASE_SRC, i[0]});
      @(posedge pclk);
      chk("idx_base", i ? 32'h15 : 32'h2a, 32'(indexed_base));
      issue({`OPC_SERIAL_SRC, i[0]});
      chk("serial", 32'(i), 32'(serial_addr_is_index));
    end
    issue({`OPC_HS_FBK, 3'h7});
    chk("fbk_denied", 32'h0, 32'({hs_fbk_battery, auto_diag_enable}));
    hs_drive_right <= 1'b1;
    issue({`OPC_HS_FBK, 3'h7});
    chk("fbk_on", 32'h3, 32'({hs_fbk_battery, auto_diag_enable}));
    issue({`OPC_HS_FBK, 3'h0});
    chk("fbk_keep", 32'h1, 32'({hs_fbk_battery, auto_diag_enable}));
    issue({`OPC_HS_FBK, 3'h6});
    chk("fbk_off", 32'h2, 32'({hs_fbk_battery, auto_diag_enable}));
    issue({`OPC_HS_FBK, 3'h1});
    chk("fbk_na", 32'h0, 32'({hs_fbk_battery, auto_diag_enable}));
    for (i = 0; i < 4; i = i + 1) issue({`OPC_CONV_MODE, 1'b1, i[1:0]});
    chk("conv_on", 32'hb, 32'(conversion_mode));
    issue({`OPC_CONV_MODE, 1'b0, 2'h1});
    chk("conv_off", 32'ha, 32'(conversion_mode));
    for (i = 3; i >= 0; i = i - 1) begin
      issue({`OPC_ARITH_MODE, i[1:0]});
      chk("arith", 32'(i), 32'(arith_mode));
    end
    // 0x7fff + 1 overflows signed; 0x7fff + 0x8001 carries out unsigned
    alu_index_register <= 16'h7fff;
    for (i = 0; i < 4; i = i + 1) begin
      issue({`OPC_ARITH_MODE, i[1:0]});
      apb(1'b1, `ADDR_CTRL, i[1] ? 32'h8001 : 32'h1);
      apb(1'b0, `ADDR_CTRL, 32'h0);
      chk("sum", i == 0 ? 32'h8000 : i == 1 ? 32'h7fff : i == 2 ? 32'h0 : 32'hffff, 32'(rd[15:0]));
      chk("ovf", 32'h1, 32'(alu_overflow));
    end
    // a sum that fits leaves the flag low
    apb(1'b1, `ADDR_CTRL, 32'h0);
    chk("ovf_clear", 32'h0, 32'(alu_overflow));
    // 0x8006 shifted by two keeps its sign and drops a one last; an empty shift leaves it
    apb(1'b1, `ADDR_ALU_REG, {13'h0, 3'h3, 16'h8006});
    issue({`OPC_SHIFT_RSI, 4'h2, 3'h3});
    chk("flags", 32'h2, 32'({shifted_out_flag, multiply_shift_overflow}));
    issue({`OPC_SHIFT_RSI, 4'h0, 3'h3});
    apb(1'b0, `ADDR_ALU_REG, {13'h0, 3'h3, 16'h0});
    chk("shifted", 32'he001, 32'(rd[15:0]));
    complete_run;
  end
endmodule
